// >>> rtl/sep_pkg.sv
// Shared constants, types and select-byte builder for both link ends
// Assumes a 250 MHz system clock and a 15 ns link sampling clock
package sep_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS                   = 4;
   localparam int LINK_NS                  = 15;
   localparam int SCL_PERIOD_NS            = 2500;
   localparam int QTR_CYC                  =
      (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
   localparam int INTERNAL_PROGRAM_TIME_MS = 10;
   localparam int PROG_CYC                 =
      INTERNAL_PROGRAM_TIME_MS * 1000000 / LINK_NS;
   localparam int POLL_MAX                 =
      INTERNAL_PROGRAM_TIME_MS * 1000000 / (11 * SCL_PERIOD_NS) + 1;

   // ****************************************
   // Fields
   // ****************************************
   // Arbitrary device type code
   localparam logic [3:0] DEV_TYPE  = 4'h6;
   localparam int         ADDR_W    = 15;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [1:0] {
      OP_WRITE      = 2'h0,
      OP_RD_RANDOM  = 2'h1,
      OP_RD_CURRENT = 2'h2
   } sep_op_e;

   // Select byte: type, fixed zero, chip code, direction
   function automatic logic [7:0] sep_select(input logic [1:0] chip,
                                             input logic       rd);
      return {DEV_TYPE, 1'h0, chip, rd};
   endfunction

endpackage

// >>> rtl/sep_link_if.sv
// Two-wire link between host end and memory end
// Assumes the testbench instantiates it and joins both ends
`timescale 1ns/1ns
`default_nettype none
interface sep_link_if;
   logic scl;
   logic sdaHostOut;
   logic sdaHostOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic sda;

   // Open-drain wired AND of both drivers
   assign sda = !((sdaHostOe && !sdaHostOut) ||
                  (sdaDevOe && !sdaDevOut));

   modport host (output scl, sdaHostOut, sdaHostOe, input sda);
   modport dev  (input scl, sda, output sdaDevOut, sdaDevOe);
endinterface
`default_nettype wire

// >>> rtl/sep_dev_end.sv
// Memory end of the two-wire link: reads, polling, write cycle
// Assumes linkClk far faster than scl and scl driven by the host
`timescale 1ns/1ns
`default_nettype none
module sep_dev_end
   import sep_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYC
) (
   // Link clock and reset
   input  wire logic linkClk,
   input  wire logic rst_b,
   // Link
   sep_link_if.dev   link,
   // Straps
   input  wire logic chipSelectPinLow,
   input  wire logic chipSelectPinHigh,
   input  wire logic writeProtectInput,
   // Status
   output var  logic progBusy
);

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [2:0] {
      D_IDLE  = 3'h0,
      D_RX    = 3'h1,
      D_RXACK = 3'h2,
      D_TX    = 3'h3,
      D_TXACK = 3'h4
   } sep_dstate_e;

   typedef enum logic [1:0] {
      K_SEL  = 2'h0,
      K_AHI  = 2'h1,
      K_ALO  = 2'h2,
      K_DATA = 2'h3
   } sep_kind_e;

   sep_dstate_e       state;
   sep_kind_e         kind;
   sep_kind_e         next_kind;
   logic [3:0]        bitCnt;
   logic [7:0]        sh;
   logic [7:0]        txSh;
   logic              ackIt;
   logic              next_ack;
   logic              hostAck;
   logic [ADDR_W-1:0] addr;
   logic              wrPend;
   logic [31:0]       progCnt;
   logic [7:0]        mem [0:(1 << ADDR_W) - 1];

   // ****************************************
   // Pin synchroniser
   // ****************************************
   logic [4:0] s1;
   logic [4:0] s2;
   logic [4:0] s3;
   logic [4:0] pins;
   logic [4:0] prev;
   logic       sclF;
   logic       sdaF;
   logic       sclRise;
   logic       sclFall;
   logic       startEv;
   logic       stopEv;
   logic [7:0] selByte;

   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         s1   <= 5'h18;
         s2   <= 5'h18;
         s3   <= 5'h18;
         pins <= 5'h18;
         prev <= 5'h18;
      end else begin
         s1   <= {link.scl, link.sda, chipSelectPinHigh,
                  chipSelectPinLow, writeProtectInput};
         s2   <= s1;
         s3   <= s2;
         pins <= (s2 & s3) | (pins & (s2 ^ s3));
         prev <= pins;
      end
   end

   assign sclF    = pins[4];
   assign sdaF    = pins[3];
   assign sclRise = sclF && !prev[4];
   assign sclFall = !sclF && prev[4];
   assign startEv = sclF && prev[4] && prev[3] && !sdaF;
   assign stopEv  = sclF && prev[4] && !prev[3] && sdaF;

   // ****************************************
   // Acknowledge decision
   // ****************************************
   assign selByte = sep_select(pins[2:1], sh[0]);

   always_comb begin
      next_kind = K_DATA;
      case (kind)
         K_SEL:   next_kind = K_AHI;
         K_AHI:   next_kind = K_ALO;
         default: next_kind = K_DATA;
      endcase
   end

   always_comb begin
      case (kind)
         K_SEL:   next_ack = (sh == selByte);
         K_DATA:  next_ack = !pins[0];
         default: next_ack = 1'h1;
      endcase
   end

   // ****************************************
   // Link state machine
   // ****************************************
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= D_IDLE;
         kind    <= K_SEL;
         bitCnt  <= 4'h0;
         sh      <= 8'h00;
         txSh    <= 8'h00;
         ackIt   <= 1'h0;
         hostAck <= 1'h0;
      end else if (stopEv) begin
         state <= D_IDLE;
      end else if (startEv && !progBusy) begin
         state  <= D_RX;
         kind   <= K_SEL;
         bitCnt <= 4'h0;
      end else begin
         case (state)
            D_RX: begin
               if (sclRise && bitCnt != BYTE_BITS) begin
                  sh     <= {sh[6:0], sdaF};
                  bitCnt <= bitCnt + 4'h1;
               end else if (sclFall && bitCnt == BYTE_BITS) begin
                  state <= D_RXACK;
                  ackIt <= next_ack;
               end
            end
            D_RXACK: begin
               if (sclFall) begin
                  bitCnt <= 4'h0;
                  if (!ackIt) begin
                     state <= D_IDLE;
                  end else if (kind == K_SEL && sh[0]) begin
                     state <= D_TX;
                     txSh  <= mem[addr];
                  end else begin
                     state <= D_RX;
                     kind  <= next_kind;
                  end
               end
            end
            D_TX: begin
               if (sclFall) begin
                  txSh   <= {txSh[6:0], 1'h0};
                  bitCnt <= bitCnt + 4'h1;
                  if (bitCnt == BYTE_BITS - 4'h1) begin
                     state <= D_TXACK;
                  end
               end
            end
            D_TXACK: begin
               if (sclRise) begin
                  hostAck <= !sdaF;
               end else if (sclFall) begin
                  bitCnt <= 4'h0;
                  if (hostAck) begin
                     state <= D_TX;
                     txSh  <= mem[addr];
                  end else begin
                     state <= D_IDLE;
                  end
               end
            end
            default: state <= D_IDLE;
         endcase
      end
   end

   // ****************************************
   // Address counter and array
   // ****************************************
   // counter kept between transfers
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         addr <= '0;
      end else if (state == D_RXACK && sclFall && ackIt) begin
         case (kind)
            K_AHI:   addr[14:8] <= sh[6:0];
            K_ALO:   addr[7:0]  <= sh;
            K_DATA:  addr[5:0]  <= addr[5:0] + 6'h01;
            default: addr       <= addr;
         endcase
      end else if (state == D_TX && sclFall &&
                   bitCnt == BYTE_BITS - 4'h1) begin
         addr <= addr + 15'h0001;
      end
   end

   always_ff @(posedge linkClk) begin
      if (state == D_RXACK && sclFall && ackIt && kind == K_DATA) begin
         mem[addr] <= sh;
      end
   end

   // ****************************************
   // Programming cycle
   // ****************************************
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         wrPend <= 1'h0;
      end else if (state == D_RXACK && sclFall) begin
         wrPend <= ackIt && kind == K_DATA;
      end else if (sclFall || startEv) begin
         wrPend <= 1'h0;
      end
   end

   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         progCnt  <= 32'h0;
         progBusy <= 1'h0;
      end else if (stopEv && wrPend && !progBusy) begin
         progCnt  <= 32'(PROG_CYCLES - 1);
         progBusy <= 1'h1;
      end else if (progCnt != 32'h0) begin
         progCnt <= progCnt - 32'h1;
      end else begin
         progBusy <= 1'h0;
      end
   end

   // ****************************************
   // Data line drive
   // ****************************************
   assign link.sdaDevOut = 1'h0;
   assign link.sdaDevOe  = (state == D_RXACK && ackIt) ||
                           (state == D_TX && !txSh[7]);

endmodule
`default_nettype wire

// >>> rtl/sep_host_end.sv
// Host end of the two-wire link: makes scl, writes, reads, polls
// Assumes scl divided from ref_clk and a consumer on rdValid/rdReady
`timescale 1ns/1ns
`default_nettype none
module sep_host_end
   import sep_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Link
   sep_link_if.host        link,
   // Command
   input  wire logic       cmdValid,
   output var  logic       cmdReady,
   input  wire sep_op_e    cmdOp,
   input  wire logic [1:0] cmdChip,
   input  wire logic [15:0] cmdAddr,
   input  wire logic [7:0] cmdLen,
   input  wire logic [7:0] cmdData,
   // Read data
   output var  logic       rdValid,
   input  wire logic       rdReady,
   output var  logic [7:0] rdData,
   // Completion
   output var  logic       done,
   output var  logic       err
);

   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [2:0] {
      M_IDLE  = 3'h0,
      M_START = 3'h1,
      M_HOLD  = 3'h2,
      M_BYTE  = 3'h3,
      M_STOP  = 3'h4
   } sep_hstate_e;

   typedef enum logic [2:0] {
      S_SEL1 = 3'h0,
      S_AHI  = 3'h1,
      S_ALO  = 3'h2,
      S_DATA = 3'h3,
      S_SEL2 = 3'h4,
      S_RD   = 3'h5
   } sep_step_e;

   sep_hstate_e state;
   sep_step_e   step;
   sep_op_e     op;
   logic [1:0]  chip;
   logic [15:0] addrR;
   logic [7:0]  dataR;
   logic [7:0]  left;
   logic [7:0]  sh;
   logic [3:0]  bitCnt;
   logic [8:0]  tries;
   logic        ackSeen;
   logic        retry;
   logic        errFlag;
   logic        scl;
   logic        sdaOe;
   logic [7:0]  qCnt;
   logic [1:0]  phase;
   logic        tick;
   logic        rd;
   logic        ackOut;
   logic        push;
   logic [2:0]  s;
   logic        sdaF;
   logic [7:0]  fMem [0:1];
   logic        fWp;
   logic        fRp;
   logic [1:0]  fCnt;

   function automatic logic [7:0] host_byte(input sep_step_e st);
      case (st)
         S_SEL1:  return sep_select(chip, op == OP_RD_CURRENT);
         S_AHI:   return addrR[15:8];
         S_ALO:   return addrR[7:0];
         S_DATA:  return dataR;
         S_SEL2:  return sep_select(chip, 1'h1);
         default: return 8'hFF;
      endcase
   endfunction

   // ****************************************
   // Data line synchroniser and divider
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         s    <= 3'h7;
         sdaF <= 1'h1;
      end else begin
         s <= {s[1:0], link.sda};
         if (s[1] == s[2]) begin
            sdaF <= s[2];
         end
      end
   end

   assign tick = (qCnt == 8'(QTR_CYC - 1));

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         qCnt <= 8'h00;
      end else if (state == M_IDLE || tick) begin
         qCnt <= 8'h00;
      end else begin
         qCnt <= qCnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= 2'h0;
      end else if (state == M_IDLE || state == M_HOLD) begin
         phase <= 2'h0;
      end else if (tick) begin
         phase <= phase + 2'h1;
      end
   end

   assign rd     = (step == S_RD);
   assign ackOut = (left > 8'h01);
   assign push   = state == M_BYTE && tick && phase == 2'h3 &&
                   bitCnt == BYTE_BITS && rd;

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= M_IDLE;
         step    <= S_SEL1;
         op      <= OP_WRITE;
         chip    <= 2'h0;
         addrR   <= 16'h0000;
         dataR   <= 8'h00;
         left    <= 8'h00;
         sh      <= 8'h00;
         bitCnt  <= 4'h0;
         tries   <= 9'h000;
         ackSeen <= 1'h0;
         retry   <= 1'h0;
         errFlag <= 1'h0;
         scl     <= 1'h1;
         sdaOe   <= 1'h0;
         done    <= 1'h0;
         err     <= 1'h0;
      end else begin
         done <= 1'h0;
         err  <= 1'h0;
         case (state)
            M_IDLE: begin
               if (cmdValid) begin
                  op      <= cmdOp;
                  chip    <= cmdChip;
                  addrR   <= cmdAddr;
                  dataR   <= cmdData;
                  left    <= (cmdLen == 8'h00) ? 8'h01 : cmdLen;
                  tries   <= 9'h000;
                  errFlag <= 1'h0;
                  step    <= S_SEL1;
                  state   <= M_START;
               end
            end
            M_START: begin
               if (tick) begin
                  case (phase)
                     2'h0:    sdaOe <= 1'h0;
                     2'h1:    scl   <= 1'h1;
                     2'h2:    sdaOe <= 1'h1;
                     default: begin
                        scl   <= 1'h0;
                        state <= M_HOLD;
                     end
                  endcase
               end
            end
            M_HOLD: begin
               if (tick && (!rd || fCnt != 2'h2)) begin
                  sh     <= host_byte(step);
                  bitCnt <= 4'h0;
                  state  <= M_BYTE;
               end
            end
            M_BYTE: begin
               if (tick) begin
                  case (phase)
                     2'h0: begin
                        if (bitCnt == BYTE_BITS) begin
                           sdaOe <= rd && ackOut;
                        end else begin
                           sdaOe <= !rd && !sh[7];
                        end
                     end
                     2'h1: scl <= 1'h1;
                     2'h2: begin
                        if (bitCnt == BYTE_BITS) begin
                           ackSeen <= !sdaF;
                        end else begin
                           sh <= {sh[6:0], rd ? sdaF : 1'h0};
                        end
                     end
                     default: begin
                        scl <= 1'h0;
                        if (bitCnt != BYTE_BITS) begin
                           bitCnt <= bitCnt + 4'h1;
                        end else if (rd) begin
                           left  <= left - 8'h01;
                           state <= ackOut ? M_HOLD : M_STOP;
                        end else if (!ackSeen) begin
                           state <= M_STOP;
                           tries <= tries + 9'h001;
                           if (step == S_SEL1 &&
                               tries != 9'(POLL_MAX - 1)) begin
                              retry <= 1'h1;
                           end else begin
                              errFlag <= 1'h1;
                           end
                        end else begin
                           case (step)
                              S_SEL1: begin
                                 step  <= (op == OP_RD_CURRENT) ?
                                          S_RD : S_AHI;
                                 state <= M_HOLD;
                              end
                              S_AHI: begin
                                 step  <= S_ALO;
                                 state <= M_HOLD;
                              end
                              S_ALO: begin
                                 step  <= (op == OP_WRITE) ?
                                          S_DATA : S_SEL2;
                                 state <= (op == OP_WRITE) ?
                                          M_HOLD : M_START;
                              end
                              S_SEL2: begin
                                 step  <= S_RD;
                                 state <= M_HOLD;
                              end
                              default: state <= M_STOP;
                           endcase
                        end
                     end
                  endcase
               end
            end
            M_STOP: begin
               if (tick) begin
                  case (phase)
                     2'h0:    sdaOe <= 1'h1;
                     2'h1:    scl   <= 1'h1;
                     2'h2:    sdaOe <= 1'h0;
                     default: begin
                        if (retry) begin
                           retry <= 1'h0;
                           step  <= S_SEL1;
                           state <= M_START;
                        end else begin
                           done  <= 1'h1;
                           err   <= errFlag;
                           state <= M_IDLE;
                        end
                     end
                  endcase
               end
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   // ****************************************
   // Two-entry read buffer
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         fWp  <= 1'h0;
         fRp  <= 1'h0;
         fCnt <= 2'h0;
      end else begin
         if (push) begin
            fWp <= !fWp;
         end
         if (rdValid && rdReady) begin
            fRp <= !fRp;
         end
         fCnt <= fCnt + {1'h0, push} - {1'h0, rdValid && rdReady};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         fMem[fWp] <= sh;
      end
   end

   assign rdValid         = (fCnt != 2'h0);
   assign rdData          = fMem[fRp];
   assign cmdReady        = (state == M_IDLE);
   assign link.scl        = scl;
   assign link.sdaHostOut = 1'h0;
   assign link.sdaHostOe  = sdaOe;

endmodule
`default_nettype wire

// >>> verif/sep_link_chk.sv
// Assertions on the two-wire link between both ends
// Assumes link wires, busy flag and linkClk from the bench
`timescale 1ns/1ns
`default_nettype none
module sep_link_chk #(
   parameter int PROG_CYCLES = 2000
) (
   // Clock and reset
   input wire logic linkClk,
   input wire logic rst_b,
   // Link
   input wire logic scl,
   input wire logic sdaHostOe,
   input wire logic sdaDevOe,
   input wire logic sda,
   // Status
   input wire logic progBusy
);
   // ********************
   // Busy counter
   // ********************
   int busyCnt;
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         busyCnt <= 0;
      end else begin
         busyCnt <= progBusy ? busyCnt + 1 : 0;
      end
   end
   // ********************
   // Properties
   // ********************
   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!rst_b);
   sequence startCond;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence stopCond;
      scl && $past(scl) && $rose(sda);
   endsequence
   busy_no_drive_a: assert property (
      progBusy |-> !sdaDevOe && (sda == !sdaHostOe))
      else $error("memory end drives sda while busy");
   prog_after_stop_a: assert property (
      $rose(progBusy) |-> scl && sda)
      else $error("write cycle began without stop");
   prog_max_len_a: assert property (
      progBusy |-> busyCnt <= PROG_CYCLES + 4)
      else $error("write cycle too long");
   prog_min_len_a: assert property (
      $fell(progBusy) |-> $past(busyCnt) >= PROG_CYCLES - 4)
      else $error("write cycle too short");
   drive_hold_a: assert property (
      scl && $past(scl) |-> $stable(sdaDevOe))
      else $error("sda drive changed while scl high");
   drive_low_a: assert property (
      $changed(sdaDevOe) |-> !scl)
      else $error("sda drive changed at scl high");
   start_free_a: assert property (
      startCond |-> ##1 !sdaDevOe [*8])
      else $error("memory end holds sda at start");
   stop_quiet_a: assert property (
      stopCond |-> !sdaDevOe [*8])
      else $error("memory end drives sda after stop");
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Bench joining host end and memory end over the link
// Assumes the link interface and both ends from rtl
`timescale 1ns/1ns
`default_nettype none
module testbench import sep_pkg::*; ;
   logic        ref_clk = 1'b0;
   logic        linkClk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cmdValid = 1'b0;
   sep_op_e     cmdOp = OP_WRITE;
   logic [15:0] cmdAddr = 16'h0000;
   logic [7:0]  cmdLen = 8'h00;
   logic [7:0]  cmdData = 8'h00;
   logic        rdReady = 1'b0;
   logic        wp = 1'b0;
   logic        cmdReady, rdValid, done, err, progBusy;
   logic [7:0]  rdData;
   int          errors = 0;
   int          num_checks = 0;
   // ********************
   // Clocks and parts
   // ********************
   always #2 ref_clk = ~ref_clk;
   always begin
      #7 linkClk = ~linkClk;
      #8 linkClk = ~linkClk;
   end
   sep_link_if i_sep_link_if ();
   sep_host_end i_sep_host_end (.ref_clk(ref_clk), .rst_b(rst_b),
      .link(i_sep_link_if), .cmdValid(cmdValid), .cmdReady(cmdReady),
      .cmdOp(cmdOp), .cmdChip(2'h1), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
      .cmdData(cmdData), .rdValid(rdValid), .rdReady(rdReady),
      .rdData(rdData), .done(done), .err(err));
   sep_dev_end #(.PROG_CYCLES(400)) i_sep_dev_end (.linkClk(linkClk),
      .rst_b(rst_b), .link(i_sep_link_if), .chipSelectPinLow(1'b1),
      .chipSelectPinHigh(1'b0), .writeProtectInput(wp),
      .progBusy(progBusy));
   sep_link_chk #(.PROG_CYCLES(400)) chk (.linkClk(linkClk),
      .rst_b(rst_b), .scl(i_sep_link_if.scl),
      .sdaHostOe(i_sep_link_if.sdaHostOe),
      .sdaDevOe(i_sep_link_if.sdaDevOe), .sda(i_sep_link_if.sda),
      .progBusy(progBusy));
   // ********************
   // Tasks
   // ********************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic run_cmd(input sep_op_e op, input logic [15:0] a,
                          input logic [7:0] n, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      {cmdOp, cmdAddr, cmdLen, cmdData} <= {op, a, n, d};
      cmdValid <= 1'b1;
      @(negedge ref_clk);
      while (cmdReady !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (done !== 1'b1 && k < 60000);
      check({7'h00, done}, 8'h01);
      check({7'h00, err}, 8'h00);
   endtask
   task automatic pop(input logic [7:0] exp);
      @(negedge ref_clk);
      check({7'h00, rdValid}, 8'h01);
      check(rdData, exp);
      @(posedge ref_clk);
      rdReady <= 1'b1;
      @(posedge ref_clk);
      rdReady <= 1'b0;
   endtask
   // ********************
   // Tests
   // ********************
   initial begin
      repeat (130000) @(posedge ref_clk);
      errors++;
      test_done;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      // Top address with b15 set, then zero behind a busy cycle
      run_cmd(OP_WRITE, 16'hFFFF, 8'h00, 8'h5A);
      check({7'h00, progBusy}, 8'h01);
      run_cmd(OP_WRITE, 16'h0000, 8'h00, 8'hC3);
      // Two-byte read across the wrap, receiver stalled
      @(posedge ref_clk);
      wp <= 1'b1;
      run_cmd(OP_RD_RANDOM, 16'hFFFF, 8'h02, 8'h00);
      repeat (500) @(posedge ref_clk);
      pop(8'h5A);
      pop(8'hC3);
      @(negedge ref_clk);
      check({7'h00, rdValid}, 8'h00);
      test_done;
   end
endmodule
`default_nettype wire
